// *** ssd_pkg.sv ***
// Purpose: constants and carriers for the second synthesizer divider register bank
// Assumes: AXI4-Lite register access, 32-bit data, one byte register per aligned word
// Notes:   printed offsets are not all multiples of four, so they are indices (byte addr = 4 * index)
package ssd_pkg;

  // ==========================================================================
  // register indices and byte address width
  localparam logic [7:0] IDX_CONTROL_ONE  = 8'h48;
  localparam logic [7:0] IDX_INT_DIV_HIGH = 8'h49;
  localparam logic [7:0] IDX_INT_DIV_LOW  = 8'h4a;
  localparam logic [7:0] IDX_NUMER_HIGH   = 8'h4b;
  localparam logic [7:0] IDX_NUMER_MID    = 8'h4c;
  localparam logic [7:0] IDX_NUMER_LOW    = 8'h4d;
  localparam logic [7:0] IDX_DENOM_HIGH   = 8'h4e;
  localparam logic [7:0] IDX_DENOM_MID    = 8'h4f;
  localparam logic [7:0] IDX_DENOM_LOW    = 8'h50;
  localparam int         ADDR_W           = 10;
  localparam int         IDX_LSB          = 2;

  // ==========================================================================
  // reset values
  localparam logic [3:0]  RST_PUMP_GAIN   = 4'h8;
  localparam logic        RST_DOUBLER_EN  = 1'b1;
  localparam logic        RST_CTRL_RSVD   = 1'b0;
  localparam logic [11:0] RST_INT_DIVIDER = 12'h064;
  localparam logic [21:0] RST_FRAC        = 22'h000000;

  // ==========================================================================
  // field layout of the control register
  localparam int PUMP_LSB    = 0;
  localparam int DOUBLER_BIT = 4;
  localparam int CTRL_RSVD   = 5;

  // ==========================================================================
  // pump current in units of 0.1 mA
  localparam logic [3:0] PUMP_CODE_MAX_STEP = 4'h7;
  localparam logic [3:0] PUMP_CODE_HIGH     = 4'h8;
  localparam logic [6:0] PUMP_STEP_TENTHS   = 7'h04;
  localparam logic [6:0] PUMP_HIGH_TENTHS   = 7'h40;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SSD_WR_IDLE = 2'b00,
    SSD_WR_RESP = 2'b01
  } ssd_wr_state_t;

  typedef struct packed {
    logic        ctrlRsvd;
    logic        secondary_ref_doubler_en;
    logic [3:0]  second_synth_pump_gain;
    logic [11:0] second_synth_int_divider;
    logic [21:0] second_synth_frac_numer;
    logic [21:0] second_synth_frac_denom;
  } ssd_cfg_t;

endpackage

// *** ssd_regs.sv ***
// Purpose: AXI4-Lite register bank for the second fractional-N synthesizer
// Assumes: single clock, one write and one read outstanding at a time
// Notes:   byte registers in bits 7:0 of each word, upper bits read zero
//          decoded pump current and divide ratio trail the config by one cycle
//          a write is taken only once both address and data have been held
//          pump current output counts in tenths of a milliamp
//
// Functional notes
// - doubler enable bit drives doubler, resets one
// - pump gain code selects current, reset eight
// - twelve-bit divider, zero and one divide one
// - upper divider register holds bits eleven to eight
// - lower divider byte resets to one hundred
// - numerator 22 bits over three registers
// - denominator 22 bits over three registers
`timescale 1ns/1ps
`default_nettype none
module ssd_regs
  import ssd_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic [ssd_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  input  wire logic [ssd_pkg::ADDR_W-1:0] araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  output logic                         secondaryRefDoublerEn,
  output logic [3:0]                   secondSynthPumpGain,
  output logic [6:0]                   pumpCurrentTenthsMa,
  output logic [11:0]                  secondSynthIntDivider,
  output logic [11:0]                  divideRatio,
  output logic [21:0]                  secondSynthFracNumer,
  output logic [21:0]                  secondSynthFracDenom
);
  import ssd_pkg::*;

  // ==========================================================================
  // write channel
  // stored image of all nine registers
  ssd_cfg_t      cfg, next_cfg;
  ssd_wr_state_t wrState, next_wrState;
  logic          awHeld, next_awHeld;
  logic          wHeld, next_wHeld;
  logic [7:0]    awIdx, next_awIdx;
  logic [7:0]    wByte, next_wByte;
  logic          wLane, next_wLane;
  logic [1:0]    next_bresp;
  logic          doWrite;
  logic          hit;

  // each ready stays low while its own half is held or a response waits
  assign awready = (wrState == SSD_WR_IDLE) && !awHeld;
  assign wready  = (wrState == SSD_WR_IDLE) && !wHeld;
  assign bvalid  = (wrState == SSD_WR_RESP);

  // address and data are latched separately so either may arrive first
  always_comb begin
    next_awHeld  = awHeld;
    next_wHeld   = wHeld;
    next_awIdx   = awIdx;
    next_wByte   = wByte;
    next_wLane   = wLane;
    next_wrState = wrState;
    next_bresp   = bresp;
    next_cfg     = cfg;
    doWrite      = 1'b0;
    hit          = 1'b0;
    if (awvalid && awready) begin
      next_awHeld = 1'b1;
      next_awIdx  = awaddr[ssd_pkg::ADDR_W-1:IDX_LSB];
    end
    if (wvalid && wready) begin
      next_wHeld = 1'b1;
      next_wByte = wdata[7:0];
      next_wLane = wstrb[0];
    end
    // the response waits for bready before the next address is taken
    case (wrState)
      SSD_WR_IDLE: begin
        doWrite = next_awHeld && next_wHeld;
      end
      SSD_WR_RESP: begin
        if (bready) begin
          next_wrState = SSD_WR_IDLE;
        end
      end
      default: begin
        next_wrState = SSD_WR_IDLE;
      end
    endcase
    if (doWrite) begin
      next_awHeld  = 1'b0;
      next_wHeld   = 1'b0;
      next_wrState = SSD_WR_RESP;
      hit          = 1'b1;
      // only byte lane 0 carries register bits; reserved bits are dropped except control bit 5, which is stored
      if (next_wLane) begin
        case (next_awIdx)
          IDX_CONTROL_ONE: begin
            next_cfg.ctrlRsvd                 = next_wByte[CTRL_RSVD];
            next_cfg.secondary_ref_doubler_en = next_wByte[DOUBLER_BIT];
            next_cfg.second_synth_pump_gain   = next_wByte[PUMP_LSB +: 4];
          end
          IDX_INT_DIV_HIGH: begin
            // upper nibble is reserved and never stored
            next_cfg.second_synth_int_divider[11:8] = next_wByte[3:0];
          end
          IDX_INT_DIV_LOW: begin
            next_cfg.second_synth_int_divider[7:0] = next_wByte;
          end
          IDX_NUMER_HIGH: begin
            next_cfg.second_synth_frac_numer[21:16] = next_wByte[5:0];
          end
          IDX_NUMER_MID: begin
            next_cfg.second_synth_frac_numer[15:8] = next_wByte;
          end
          IDX_NUMER_LOW: begin
            next_cfg.second_synth_frac_numer[7:0] = next_wByte;
          end
          IDX_DENOM_HIGH: begin
            next_cfg.second_synth_frac_denom[21:16] = next_wByte[5:0];
          end
          IDX_DENOM_MID: begin
            next_cfg.second_synth_frac_denom[15:8] = next_wByte;
          end
          IDX_DENOM_LOW: begin
            next_cfg.second_synth_frac_denom[7:0] = next_wByte;
          end
          default: begin
            hit = 1'b0;
          end
        endcase
      end else begin
        // lane 0 off: nothing stored, mapped places still answer okay
        hit = (next_awIdx >= IDX_CONTROL_ONE) && (next_awIdx <= IDX_DENOM_LOW);
      end
      next_bresp = hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wrState <= SSD_WR_IDLE;
      awHeld  <= 1'b0;
      wHeld   <= 1'b0;
      awIdx   <= 8'h00;
      wByte   <= 8'h00;
      wLane   <= 1'b0;
      bresp   <= RESP_OKAY;
      // reset values double as the power-up defaults
      cfg.ctrlRsvd                 <= RST_CTRL_RSVD;
      cfg.secondary_ref_doubler_en <= RST_DOUBLER_EN;
      cfg.second_synth_pump_gain   <= RST_PUMP_GAIN;
      cfg.second_synth_int_divider <= RST_INT_DIVIDER;
      cfg.second_synth_frac_numer  <= RST_FRAC;
      cfg.second_synth_frac_denom  <= RST_FRAC;
    end else begin
      wrState <= next_wrState;
      awHeld  <= next_awHeld;
      wHeld   <= next_wHeld;
      awIdx   <= next_awIdx;
      wByte   <= next_wByte;
      wLane   <= next_wLane;
      bresp   <= next_bresp;
      cfg     <= next_cfg;
    end
  end

  // ==========================================================================
  // read channel
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        next_rvalid;
  logic [7:0]  rdByte;
  logic        rdHit;
  logic [7:0]  arIdx;

  // one read in flight: a new address waits until the answer is taken
  assign arready = !rvalid;
  assign arIdx   = araddr[ssd_pkg::ADDR_W-1:IDX_LSB];

  always_comb begin
    rdByte = 8'h00;
    rdHit  = 1'b1;
    // reserved positions are left at zero, except control bit 5, which reads back as stored
    case (arIdx)
      IDX_CONTROL_ONE: begin
        rdByte[CTRL_RSVD]    = cfg.ctrlRsvd;
        rdByte[DOUBLER_BIT]  = cfg.secondary_ref_doubler_en;
        rdByte[PUMP_LSB +: 4] = cfg.second_synth_pump_gain;
      end
      IDX_INT_DIV_HIGH: begin
        rdByte[3:0] = cfg.second_synth_int_divider[11:8];
      end
      IDX_INT_DIV_LOW: begin
        rdByte = cfg.second_synth_int_divider[7:0];
      end
      IDX_NUMER_HIGH: begin
        rdByte[5:0] = cfg.second_synth_frac_numer[21:16];
      end
      IDX_NUMER_MID: begin
        rdByte = cfg.second_synth_frac_numer[15:8];
      end
      IDX_NUMER_LOW: begin
        rdByte = cfg.second_synth_frac_numer[7:0];
      end
      IDX_DENOM_HIGH: begin
        rdByte[5:0] = cfg.second_synth_frac_denom[21:16];
      end
      IDX_DENOM_MID: begin
        rdByte = cfg.second_synth_frac_denom[15:8];
      end
      IDX_DENOM_LOW: begin
        rdByte = cfg.second_synth_frac_denom[7:0];
      end
      default: begin
        // unmapped indices answer slverr with zero data
        rdHit = 1'b0;
      end
    endcase
    next_rdata  = rdata;
    next_rresp  = rresp;
    next_rvalid = rvalid;
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rdata  = {24'h000000, rdByte};
      next_rresp  = rdHit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // the answer stands until rready, so rdata never moves under the master
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata  <= 32'h00000000;
      rresp  <= RESP_OKAY;
      rvalid <= 1'b0;
    end else begin
      rdata  <= next_rdata;
      rresp  <= next_rresp;
      rvalid <= next_rvalid;
    end
  end

  // ==========================================================================
  // decoded controls toward the analog synthesizer
  logic [6:0]  next_pump;
  logic [11:0] next_ratio;

  always_comb begin
    next_pump = 7'h00;
    // codes 0 and 9 to 15 are unassigned, so the pump is held off
    if (cfg.second_synth_pump_gain == PUMP_CODE_HIGH) begin
      next_pump = PUMP_HIGH_TENTHS;
    end else if (cfg.second_synth_pump_gain <= PUMP_CODE_MAX_STEP) begin
      next_pump = 7'(cfg.second_synth_pump_gain * PUMP_STEP_TENTHS);
    end
  end

  always_comb begin
    // zero cannot divide, so it behaves as one
    next_ratio = (cfg.second_synth_int_divider == 12'h000) ? 12'h001
                                                           : cfg.second_synth_int_divider;
  end

  // registered so the analog controls change on one clean edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pumpCurrentTenthsMa <= PUMP_HIGH_TENTHS;
      divideRatio         <= RST_INT_DIVIDER;
    end else begin
      pumpCurrentTenthsMa <= next_pump;
      divideRatio         <= next_ratio;
    end
  end

  // ==========================================================================
  // raw configuration toward the synthesizer
  assign secondaryRefDoublerEn = cfg.secondary_ref_doubler_en;
  assign secondSynthPumpGain   = cfg.second_synth_pump_gain;
  assign secondSynthIntDivider = cfg.second_synth_int_divider;
  assign secondSynthFracNumer  = cfg.second_synth_frac_numer;
  assign secondSynthFracDenom  = cfg.second_synth_frac_denom;

endmodule
`default_nettype wire

// *** ssd_regs_asserts.sv ***
// Purpose: port checks for ssd_regs
// Assumes: one clock, async active-low reset
// Notes:   bound to every ssd_regs instance
`timescale 1ns/1ps
`default_nettype none
module ssd_regs_asserts (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [3:0]  secondSynthPumpGain,
  input wire logic [6:0]  pumpCurrentTenthsMa,
  input wire logic [11:0] secondSynthIntDivider,
  input wire logic [11:0] divideRatio
);
  // ==========================================================================
  // handshakes
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence wrTaken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rdTaken;
    arvalid && arready;
  endsequence
  chk_write_resp: assert property (wrTaken |=> bvalid) else $error("write not answered");
  chk_bvalid_hold: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped");
  chk_read_resp: assert property (rdTaken |=> rvalid) else $error("read not answered");
  chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rdata moved");
  chk_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h0) else $error("rdata upper set");
  // ==========================================================================
  // decoded outputs lag their source by one cycle
  chk_pump_step: assert property (secondSynthPumpGain inside {[4'h1:4'h7]} |=>
    pumpCurrentTenthsMa == $past(secondSynthPumpGain) * 7'h04) else $error("pump step wrong");
  chk_pump_high: assert property (secondSynthPumpGain == 4'h8 |=>
    pumpCurrentTenthsMa == 7'h40) else $error("pump high wrong");
  chk_pump_off: assert property (!(secondSynthPumpGain inside {[4'h1:4'h8]}) |=>
    pumpCurrentTenthsMa == 7'h00) else $error("pump not off");
  chk_ratio_one: assert property (secondSynthIntDivider < 12'h002 |=>
    divideRatio == 12'h001) else $error("ratio not one");
  chk_ratio_pass: assert property (secondSynthIntDivider > 12'h001 |=>
    divideRatio == $past(secondSynthIntDivider)) else $error("ratio wrong");
endmodule
bind ssd_regs ssd_regs_asserts u_chk (
  .clock(clock), .rst_n(rst_n), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
  .rready(rready), .secondSynthPumpGain(secondSynthPumpGain), .pumpCurrentTenthsMa(pumpCurrentTenthsMa),
  .secondSynthIntDivider(secondSynthIntDivider), .divideRatio(divideRatio)
);
`default_nettype wire

// *** tb.sv ***
// Purpose: register tests for ssd_regs
// Assumes: AXI4-Lite master driven from this bench
// Notes:   byte address is four times the index
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin errCount++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb;
  import ssd_pkg::*;
  logic              clock = 1'h0;
  logic              rst_n = 1'h0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic              awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0]       wdata = '0, rdata;
  logic [3:0]        wstrb = '0, secondSynthPumpGain;
  logic              awready, wready, bvalid, arready, rvalid, secondaryRefDoublerEn;
  logic [1:0]        bresp, rresp;
  logic [6:0]        pumpCurrentTenthsMa;
  logic [11:0]       secondSynthIntDivider, divideRatio;
  logic [21:0]       secondSynthFracNumer, secondSynthFracDenom;
  int                errCount = 0, nTests = 0, cycles = 0;
  logic [7:0]        ix[9] = '{IDX_CONTROL_ONE, IDX_INT_DIV_HIGH, IDX_INT_DIV_LOW, IDX_NUMER_HIGH,
                       IDX_NUMER_MID, IDX_NUMER_LOW, IDX_DENOM_HIGH, IDX_DENOM_MID, IDX_DENOM_LOW};
  logic [7:0]        rv[9] = '{8'h18, 8'h00, 8'h64, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]        ones[9] = '{8'h3f, 8'h0f, 8'hff, 8'h3f, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff};
  logic [11:0]       dv[4] = '{12'h000, 12'h001, 12'h002, 12'hfff};

  ssd_regs u_dut (
    .clock(clock), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .secondaryRefDoublerEn(secondaryRefDoublerEn), .secondSynthPumpGain(secondSynthPumpGain),
    .pumpCurrentTenthsMa(pumpCurrentTenthsMa), .secondSynthIntDivider(secondSynthIntDivider),
    .divideRatio(divideRatio), .secondSynthFracNumer(secondSynthFracNumer),
    .secondSynthFracDenom(secondSynthFracDenom)
  );
  always #10 clock = ~clock;

  task automatic complete_run();
    $display("checks %0d errors %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // hang guard: a normal run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errCount++;
      complete_run();
    end
  end

  // ==========================================================================
  // bus tasks: sample at negedge, act just after the next posedge
  task automatic wr(input logic [7:0] ixw, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
    logic ta, tw, tb2;
    logic [1:0] r;
    @(posedge clock);
    awaddr <= {ixw, 2'h0};
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(negedge clock);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb2 = bvalid;
      r = bresp;
      @(posedge clock);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end while (!tb2);
    bready <= 1'h0;
    `CHK("bresp", er, r)
  endtask

  task automatic rd(input logic [7:0] ixr, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clock);
    araddr <= {ixr, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(negedge clock);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (ta) arvalid <= 1'h0;
    end while (!tr);
    rready <= 1'h0;
    `CHK("rdata", ed, d)
    `CHK("rresp", er, r)
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'h1;
    for (int i = 0; i < 9; i++) rd(ix[i], {24'h0, rv[i]}, RESP_OKAY);
    `CHK("dbl", 1'h1, secondaryRefDoublerEn)
    `CHK("cur", 7'h40, pumpCurrentTenthsMa)
    `CHK("ratio", 12'h064, divideRatio)
    for (int i = 0; i < 9; i++) wr(ix[i], 8'hff, 4'h1, RESP_OKAY);
    for (int i = 0; i < 9; i++) rd(ix[i], {24'h0, ones[i]}, RESP_OKAY);
    `CHK("cur", 7'h00, pumpCurrentTenthsMa)
    `CHK("ratio", 12'hfff, divideRatio)
    `CHK("num", 22'h3fffff, secondSynthFracNumer)
    `CHK("den", 22'h3fffff, secondSynthFracDenom)
    for (int c = 1; c < 9; c++) begin
      wr(IDX_CONTROL_ONE, {4'h2, 4'(c)}, 4'h1, RESP_OKAY);
      repeat (3) @(negedge clock);
      `CHK("cur", (c == 8) ? 7'h40 : 7'(c * 4), pumpCurrentTenthsMa)
      `CHK("dbl", 1'h0, secondaryRefDoublerEn)
      `CHK("gain", 4'(c), secondSynthPumpGain)
      rd(IDX_CONTROL_ONE, {24'h0, 4'h2, 4'(c)}, RESP_OKAY);
    end
    for (int i = 0; i < 4; i++) begin
      wr(IDX_INT_DIV_HIGH, {4'h0, dv[i][11:8]}, 4'h1, RESP_OKAY);
      wr(IDX_INT_DIV_LOW, dv[i][7:0], 4'h1, RESP_OKAY);
      repeat (3) @(negedge clock);
      `CHK("ratio", (dv[i] < 12'h002) ? 12'h001 : dv[i], divideRatio)
      `CHK("div", dv[i], secondSynthIntDivider)
    end
    for (int i = 3; i < 9; i++) wr(ix[i], 8'(8'h2a + i * 8'h33), 4'h1, RESP_OKAY);
    repeat (3) @(negedge clock);
    `CHK("num", 22'h03f629, secondSynthFracNumer)
    `CHK("den", 22'h1c8fc2, secondSynthFracDenom)
    // disabled strobe and unmapped places leave storage alone
    wr(IDX_NUMER_LOW, 8'h00, 4'h0, RESP_OKAY);
    wr(8'h51, 8'h00, 4'h1, RESP_SLVERR);
    rd(IDX_NUMER_LOW, 32'h29, RESP_OKAY);
    rd(8'h47, 32'h0, RESP_SLVERR);
    rst_n <= 1'h0;
    repeat (2) @(posedge clock);
    rst_n <= 1'h1;
    rd(IDX_CONTROL_ONE, 32'h18, RESP_OKAY);
    `CHK("ratio", 12'h064, divideRatio)
    `CHK("cur", 7'h40, pumpCurrentTenthsMa)
    complete_run();
  end
endmodule
`default_nettype wire
